/* File: logic/pewp_pkg.sv */
// package: pin timing counts, command codes and carrier structs for the eeprom host controller
package pewp_pkg;

    // clock rate
    localparam int unsigned CLK_MHZ          = 100;
    localparam int unsigned CLK_PERIOD_NS    = 10;

    // pin timing figures in their own units
    localparam int unsigned ADDR_SETUP_NS    = 10;     // margin before strobe falls
    localparam int unsigned WR_PULSE_NS      = 100;    // least strobe low width
    localparam int unsigned WR_HIGH_NS       = 50;     // least strobe high width
    localparam int unsigned ADDR_HOLD_NS     = 50;
    localparam int unsigned RD_ACCESS_NS     = 120;    // slowest grade access time
    localparam int unsigned FLOAT_NS         = 50;     // output float after deselect
    localparam int unsigned BYTE_LOAD_US     = 150;    // byte_load_window, longest gap
    localparam int unsigned WRITE_CYCLE_MS   = 10;     // standard variant
    localparam int unsigned FAST_CYCLE_MS    = 3;      // fast-write variant
    localparam int unsigned ERASE_PULSE_MS   = 10;     // erase_pulse_time
    localparam int unsigned ERASE_SETUP_US   = 5;      // setup and hold around erase pulse

    // cycle counts: least times round up, longest times round down
    localparam int unsigned WP_CYC   = (WR_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int unsigned WPH_CYC  = (WR_HIGH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int unsigned AS_CYC   = (ADDR_SETUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int unsigned AH_CYC   = (ADDR_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int unsigned ACC_CYC  = (RD_ACCESS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS + 1;
    localparam int unsigned DF_CYC   = (FLOAT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int unsigned BLC_CYC  = BYTE_LOAD_US * CLK_MHZ;           // longest, 15000
    localparam int unsigned WC_CYC   = WRITE_CYCLE_MS * 1000 * CLK_MHZ;  // 1000000
    localparam int unsigned WCF_CYC  = FAST_CYCLE_MS * 1000 * CLK_MHZ;   // 300000
    localparam int unsigned ERW_CYC  = ERASE_PULSE_MS * 1000 * CLK_MHZ;  // 1000000
    localparam int unsigned ERS_CYC  = ERASE_SETUP_US * CLK_MHZ;         // 500

    // widths
    localparam int unsigned ADDR_W   = 15;
    localparam int unsigned DATA_W   = 8;
    localparam int unsigned PAGE_LSB = 6;              // byte_in_page_bits are 5:0
    localparam int unsigned CNT_W    = 21;
    localparam int unsigned DMSB     = 7;              // data_msb_line

    // user commands
    typedef enum logic [1:0] {
        PEWP_CMD_READ  = 2'b00,
        PEWP_CMD_WRITE = 2'b01,
        PEWP_CMD_ERASE = 2'b10,
        PEWP_CMD_NONE  = 2'b11
    } pewp_cmd_t;

    // request from the user side
    typedef struct packed {
        pewp_cmd_t          cmd;
        logic [ADDR_W-1:0]  addr;
        logic [DATA_W-1:0]  data;
        logic               last;      // closes the page load
    } pewp_req_t;

    // pin group towards the device
    typedef struct packed {
        logic               cs_n;
        logic               oe_n;
        logic               we_n;
        logic               oe_hv;     // erase_high_voltage switch on output enable
        logic [ADDR_W-1:0]  addr;
    } pewp_pins_t;

endpackage : pewp_pkg

/* File: logic/pewp_timer.sv */
// module: loadable down counter flagging expiry
module pewp_timer (
    input  wire logic                        ref_clk, // system clock
    input  wire logic                        nrst,    // sync reset, active low
    input  wire logic                        load,    // start a new count
    input  wire logic [pewp_pkg::CNT_W-1:0]  count,   // cycles to run
    output logic                             done     // high while expired
);
    import pewp_pkg::*;

    logic [CNT_W-1:0] remain;

    assign done = (remain == '0);

    // count down to zero and hold
    always_ff @(posedge ref_clk) begin
        if (!nrst) begin
            remain <= '0;
        end else if (load) begin
            remain <= count;
        end else if (!done) begin
            remain <= remain - 1'b1;
        end
    end

endmodule // pewp_timer

/* File: logic/pewp_host.sv */
// module: host controller driving a byte-wide parallel eeprom through its pins
module pewp_host (
    input  wire logic                         ref_clk,   // 100 MHz clock
    input  wire logic                         nrst,      // sync reset, active low
    input  wire pewp_pkg::pewp_req_t          req,       // user request
    input  wire logic                         req_valid, // request present
    input  wire logic                         fast_part, // fast-write variant fitted
    output logic                              req_ready, // request taken at the previous edge
    output logic                              rd_valid,  // read data pulse
    output logic [pewp_pkg::DATA_W-1:0]       rd_data,   // read data
    output logic                              busy,      // programming or erase running
    output logic                              timeout,   // programming overran limit, sticky
    output pewp_pkg::pewp_pins_t              pins,      // device control and address
    output logic [pewp_pkg::DATA_W-1:0]       dq_out,    // data towards the device
    output logic                              dq_oe_n,   // low while host drives data
    input  wire logic [pewp_pkg::DATA_W-1:0]  dq_in      // data from the device
);
    import pewp_pkg::*;

    typedef enum logic [3:0] {
        S_IDLE   = 4'b0000,
        S_WSETUP = 4'b0001,
        S_WLOW   = 4'b0010,
        S_WHOLD  = 4'b0011,
        S_WGAP   = 4'b0100,
        S_POLL   = 4'b0101,
        S_PFLOAT = 4'b0110,
        S_RACC   = 4'b0111,
        S_RFLOAT = 4'b1000,
        S_ESETUP = 4'b1001,
        S_EPULSE = 4'b1010,
        S_EHOLD  = 4'b1011
    } pewp_state_t;

    ////////////////////////////////////////////////////////////////////////////////
    // state and holding registers

    pewp_state_t              state;
    pewp_state_t              next_state;
    logic [CNT_W-1:0]         phase;        // short phase counter
    logic [ADDR_W-1:0]        last_addr;    // last byte written, polled
    logic [DATA_W-1:0]        last_data;
    logic [ADDR_W-PAGE_LSB-1:0] page;       // page of the open load
    logic                     load_open;
    logic                     tmr_load;
    logic [CNT_W-1:0]         tmr_count;
    logic                     tmr_done;
    logic                     wc_load;
    logic                     wc_done;
    logic                     poll_msb;     // msb seen at the close of a poll read

    // byte-load window and write-cycle limit timers
    pewp_timer u_blc (
        .ref_clk (ref_clk),
        .nrst    (nrst),
        .load    (tmr_load),
        .count   (tmr_count),
        .done    (tmr_done)
    );

    pewp_timer u_wc (
        .ref_clk (ref_clk),
        .nrst    (nrst),
        .load    (wc_load),
        .count   (fast_part ? CNT_W'(WCF_CYC) : CNT_W'(WC_CYC)),
        .done    (wc_done)
    );

    ////////////////////////////////////////////////////////////////////////////////
    // decode of requests and phase ends

    wire phase_end  = (phase == '0);
    wire is_read    = req_valid && (req.cmd == PEWP_CMD_READ);
    wire is_write   = req_valid && (req.cmd == PEWP_CMD_WRITE);
    wire is_erase   = req_valid && (req.cmd == PEWP_CMD_ERASE);
    wire same_page  = (req.addr[ADDR_W-1:PAGE_LSB] == page);
    // a write may join the open load only on the same page, in time
    wire join_load  = is_write && load_open && same_page && !tmr_done;
    // the bus has floated by the end of the float phase, so use the captured bit
    wire poll_done  = (poll_msb == last_data[DMSB]);
    wire take_idle  = (state == S_IDLE) && (is_read || is_write || is_erase);
    wire take_gap   = (state == S_WGAP) && join_load;
    wire take       = take_idle || take_gap;

    // next state selection
    always_comb begin
        next_state = state;
        case (state)
            S_IDLE:   next_state = is_write ? S_WSETUP : is_read ? S_RACC : is_erase ? S_ESETUP : S_IDLE;
            S_WSETUP: next_state = phase_end ? S_WLOW : S_WSETUP;
            S_WLOW:   next_state = phase_end ? S_WHOLD : S_WLOW;
            S_WHOLD:  next_state = phase_end ? S_WGAP : S_WHOLD;
            // close the load by the user, or let the window run out
            S_WGAP:   next_state = take_gap ? S_WSETUP
                                 : (load_open && !tmr_done) ? S_WGAP : S_POLL;
            S_POLL:   next_state = phase_end ? S_PFLOAT : S_POLL;
            S_PFLOAT: next_state = !phase_end ? S_PFLOAT
                                 : (poll_done || wc_done) ? S_IDLE : S_POLL;
            S_RACC:   next_state = phase_end ? S_RFLOAT : S_RACC;
            S_RFLOAT: next_state = phase_end ? S_IDLE : S_RFLOAT;
            S_ESETUP: next_state = phase_end ? S_EPULSE : S_ESETUP;
            S_EPULSE: next_state = tmr_done ? S_EHOLD : S_EPULSE;
            S_EHOLD:  next_state = phase_end ? S_IDLE : S_EHOLD;
            default:  next_state = S_IDLE;
        endcase
    end

    // phase length of the state entered next
    wire entering = (next_state != state) || (take_gap);
    logic [CNT_W-1:0] next_phase;
    always_comb begin
        case (next_state)
            S_WSETUP: next_phase = CNT_W'(AS_CYC);
            S_WLOW:   next_phase = CNT_W'(WP_CYC - 1);
            S_WHOLD:  next_phase = CNT_W'(AH_CYC > WPH_CYC ? AH_CYC - 1 : WPH_CYC - 1);
            S_POLL:   next_phase = CNT_W'(ACC_CYC - 1);
            S_PFLOAT: next_phase = CNT_W'(DF_CYC - 1);
            S_RACC:   next_phase = CNT_W'(ACC_CYC - 1);
            S_RFLOAT: next_phase = CNT_W'(DF_CYC - 1);
            S_ESETUP: next_phase = CNT_W'(ERS_CYC - 1);
            S_EHOLD:  next_phase = CNT_W'(ERS_CYC - 1);
            default:  next_phase = '0;
        endcase
    end

    // timer starts: window at each strobe rise, erase at pulse start
    assign tmr_load  = (state == S_WLOW && phase_end) || (state == S_ESETUP && phase_end);
    assign tmr_count = (state == S_ESETUP) ? CNT_W'(ERW_CYC) : CNT_W'(BLC_CYC - 1);
    assign wc_load   = (state == S_WGAP) && (next_state == S_POLL);

    ////////////////////////////////////////////////////////////////////////////////
    // pin values computed from the next state

    wire next_wr    = (next_state == S_WSETUP) || (next_state == S_WLOW) || (next_state == S_WHOLD);
    wire next_rd    = (next_state == S_RACC) || (next_state == S_POLL);
    wire next_er    = (next_state == S_ESETUP) || (next_state == S_EPULSE) || (next_state == S_EHOLD);
    // select and write strobe fall together; the later fall latches address
    wire next_cs_n  = !(next_wr ? (next_state == S_WLOW) : (next_rd || next_er));
    wire next_we_n  = !((next_state == S_WLOW) || (next_state == S_EPULSE));
    // output enable stays high around the whole write
    wire next_oe_n  = !next_rd;
    wire next_hv    = next_er;
    wire next_dq_oe = !next_wr;     // release dq when reading or erasing

    ////////////////////////////////////////////////////////////////////////////////
    // registers

    // sequencer
    always_ff @(posedge ref_clk) begin
        if (!nrst) begin
            state <= S_IDLE;
            phase <= '0;
        end else begin
            state <= next_state;
            phase <= entering ? next_phase : (phase_end ? phase : phase - 1'b1);
        end
    end

    // page load bookkeeping, page fixed for the whole load
    always_ff @(posedge ref_clk) begin
        if (!nrst) begin
            load_open <= 1'b0;
            page      <= '0;
            last_addr <= '0;
            last_data <= '0;
        end else if (take && is_write) begin
            load_open <= !req.last;
            page      <= req.addr[ADDR_W-1:PAGE_LSB];
            last_addr <= req.addr;
            last_data <= req.data;
        end else if (state == S_WGAP && (tmr_done || next_state == S_POLL)) begin
            load_open <= 1'b0;
        end
    end

    // poll result taken while the device still drives the bus
    always_ff @(posedge ref_clk) begin
        if (!nrst) begin
            poll_msb <= 1'b0;
        end else if (state == S_POLL && phase_end) begin
            poll_msb <= dq_in[DMSB];
        end
    end

    // pins, data bus and user answers
    always_ff @(posedge ref_clk) begin
        if (!nrst) begin
            pins      <= '{cs_n: 1'b1, oe_n: 1'b1, we_n: 1'b1, oe_hv: 1'b0, addr: '0};
            dq_out    <= '0;
            dq_oe_n   <= 1'b1;
            req_ready <= 1'b0;
            rd_valid  <= 1'b0;
            rd_data   <= '0;
            busy      <= 1'b0;
            timeout   <= 1'b0;
        end else begin
            pins.cs_n  <= next_cs_n;
            pins.we_n  <= next_we_n;
            pins.oe_n  <= next_oe_n;
            pins.oe_hv <= next_hv;
            pins.addr  <= take ? req.addr : (next_state == S_POLL ? last_addr : pins.addr);
            dq_out     <= take ? req.data : dq_out;
            dq_oe_n    <= next_dq_oe;
            req_ready  <= take;
            rd_valid   <= (state == S_RACC) && phase_end;
            rd_data    <= ((state == S_RACC) && phase_end) ? dq_in : rd_data;
            busy       <= (next_state == S_POLL) || (next_state == S_PFLOAT) || next_er;
            timeout    <= timeout || ((state == S_PFLOAT) && phase_end && wc_done && !poll_done);
        end
    end

endmodule // pewp_host

/* File: testbench/pewp_host_sva.sv */
// checker: pin-level behaviour of the eeprom host controller
module pewp_host_sva (
    input wire logic                         ref_clk,   // 100 MHz clock
    input wire logic                         nrst,      // sync reset, active low
    input wire pewp_pkg::pewp_req_t          req,       // user request
    input wire logic                         req_valid, // request present
    input wire logic                         fast_part, // fast-write variant
    input wire logic                         req_ready, // request taken
    input wire logic                         rd_valid,  // read data pulse
    input wire logic [pewp_pkg::DATA_W-1:0]  rd_data,   // read data
    input wire logic                         busy,      // programming running
    input wire logic                         timeout,   // limit overrun
    input wire pewp_pkg::pewp_pins_t         pins,      // device pins
    input wire logic [pewp_pkg::DATA_W-1:0]  dq_out,    // host data
    input wire logic                         dq_oe_n,   // low while host drives
    input wire logic [pewp_pkg::DATA_W-1:0]  dq_in      // device data
);
    timeunit 1ns;
    timeprecision 1ps;
    import pewp_pkg::*;
    logic                       we_q;
    logic                       load_open;
    logic [ADDR_W-PAGE_LSB-1:0] page_q;
    wire                        we_fall = we_q && !pins.we_n;
    wire                        wr_ovl  = !pins.we_n && !pins.cs_n;
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!nrst);
    ////////////////////////////////////////
    // page of the open load, closed once polling starts
    always_ff @(posedge ref_clk) begin
        we_q <= !nrst ? 1'b1 : pins.we_n;
        if (!nrst || !pins.oe_n) begin
            load_open <= 1'b0;
        end else if (we_fall) begin
            load_open <= 1'b1;
            page_q    <= pins.addr[ADDR_W-1:PAGE_LSB];
        end
    end
    ////////////////////////////////////////
    // strobe low for ten cycles, then high
    sequence s_low8; wr_ovl [*8]; endsequence
    sequence s_low2; wr_ovl [*2]; endsequence
    a_oe_high_write: assert property (wr_ovl |-> pins.oe_n)
        else $error("output enable low during write overlap");
    a_dq_only_write: assert property (!dq_oe_n |-> pins.oe_n)
        else $error("host drives data while device may drive");
    a_dq_over_strobe: assert property (wr_ovl && !pins.oe_hv |-> !dq_oe_n)
        else $error("data not driven during write strobe");
    a_pulse_width: assert property (we_fall && !pins.oe_hv |-> s_low8 ##1 s_low2 ##1 pins.we_n)
        else $error("write strobe width wrong");
    a_page_same: assert property (we_fall && load_open |-> pins.addr[ADDR_W-1:PAGE_LSB] == page_q)
        else $error("page bits changed within a load");
    a_erase_float: assert property (pins.oe_hv |-> dq_oe_n && !pins.cs_n)
        else $error("erase without select or with data driven");
    a_no_write_busy: assert property (busy && !pins.oe_hv |-> pins.we_n)
        else $error("write strobe while programming");
    a_rd_after_oe: assert property (rd_valid |-> !$past(pins.oe_n) && !$past(pins.cs_n))
        else $error("read data without output enable");
    a_ready_cause: assert property (req_ready |-> $past(req_valid) && $stable(timeout))
        else $error("request taken without request");
endmodule // pewp_host_sva

/* File: testbench/pewp_dev_model.sv */
// partner model: byte-wide eeprom with page buffer and self-timed programming
module pewp_dev_model #(
    parameter int WIN_CYC  = 60,  // shortened byte_load_window
    parameter int PROG_CYC = 40   // programming time, under the cycle limit
) (
    input  wire logic                         ref_clk, // model timebase
    input  wire pewp_pkg::pewp_pins_t         pins,    // host control and address
    input  wire logic [pewp_pkg::DATA_W-1:0]  dq_host, // host data
    output logic      [pewp_pkg::DATA_W-1:0]  dq_dev   // data back to the host
);
    timeunit 1ns;
    timeprecision 1ps;
    import pewp_pkg::*;
    logic [DATA_W-1:0] mem [int];
    logic [ADDR_W-1:0] pa [$];
    logic [DATA_W-1:0] pd [$];
    logic [ADDR_W-1:0] lat_a;
    logic [ADDR_W-1:0] last_a;
    logic [DATA_W-1:0] last_d;
    logic              wr_q = 1'b0;
    int                win  = 0;
    int                prog = 0;
    wire wr = !pins.cs_n && !pins.we_n && pins.oe_n && !pins.oe_hv; // write mode
    wire rd = !pins.cs_n && !pins.oe_n && pins.we_n && !pins.oe_hv; // read mode
    ////////////////////////////////////////
    // polled byte shows inverted msb until done
    function automatic logic [DATA_W-1:0] rd_val(input logic [ADDR_W-1:0] a);
        if ((win > 0 || prog > 0) && a == last_a) return {~last_d[DMSB], last_d[DMSB-1:0]};
        return mem.exists(a) ? mem[a] : 8'hff;
    endfunction
    ////////////////////////////////////////
    // latching, load window, programming, erase and output
    always @(posedge ref_clk) begin
        if (wr && !wr_q) lat_a = pins.addr;
        if (!wr && wr_q) begin
            pa.push_back(lat_a);
            pd.push_back(dq_host);
            last_a = lat_a;
            last_d = dq_host;
            win = WIN_CYC;
        end else if (win > 0) begin
            win--;
            if (win == 0) begin
                foreach (pa[i]) mem[pa[i]] = pd[i];
                pa.delete();
                pd.delete();
                prog = PROG_CYC;
            end
        end else if (prog > 0) begin
            prog--;
        end
        wr_q = wr;
        if (pins.oe_hv && !pins.cs_n && !pins.we_n) mem.delete();
        dq_dev <= rd ? rd_val(pins.addr) : ~dq_dev;
    end
endmodule // pewp_dev_model

/* File: testbench/tb_top.sv */
// testbench: host controller against the eeprom model
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    import pewp_pkg::*;
    logic ref_clk, nrst, req_valid, fast_part, req_ready, rd_valid, busy, timeout, dq_oe_n;
    pewp_req_t         req;
    pewp_pins_t        pins;
    logic [DATA_W-1:0] rd_data, dq_out, dq_in;
    int                fail_count = 0;
    int                checks = 0;
    always #5 ref_clk = ~ref_clk;
    pewp_host dut (.ref_clk(ref_clk), .nrst(nrst), .req(req), .req_valid(req_valid), .fast_part(fast_part),
        .req_ready(req_ready), .rd_valid(rd_valid), .rd_data(rd_data), .busy(busy), .timeout(timeout),
        .pins(pins), .dq_out(dq_out), .dq_oe_n(dq_oe_n), .dq_in(dq_in));
    pewp_dev_model dev (.ref_clk(ref_clk), .pins(pins), .dq_host(dq_out), .dq_dev(dq_in));
    ////////////////////////////////////////
    // compare, give up and verdict
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        checks++;
        if (seen !== exp) begin
            fail_count++;
            $display("FAIL t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic report_and_stop();
        $display("checks=%0d fail_count=%0d", checks, fail_count);
        if (fail_count == 0 && checks > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask
    task automatic give_up();
        fail_count++;
        report_and_stop();
    endtask
    ////////////////////////////////////////
    // request, read and completion helpers
    task automatic send(input pewp_cmd_t c, input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d, input logic l);
        int n;
        // let one edge pass with valid low, so a stale ready pulse is never mistaken
        @(negedge ref_clk);
        req = '{c, a, d, l};
        req_valid = 1'b1;
        @(negedge ref_clk);
        for (n = 1; n < 4000 && req_ready !== 1'b1; n++) @(negedge ref_clk);
        if (req_ready !== 1'b1) give_up();
        req_valid = 1'b0;
    endtask
    task automatic rd(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] e);
        int n;
        send(PEWP_CMD_READ, a, 8'h00, 1'b0);
        for (n = 0; n < 40 && rd_valid !== 1'b1; n++) @(negedge ref_clk);
        if (n == 40) give_up();
        check({8'h00, rd_data}, {8'h00, e});
    endtask
    task automatic wait_idle();
        int n;
        for (n = 0; n < 200 && busy !== 1'b1; n++) @(negedge ref_clk);
        check({15'h0000, busy}, 16'h0001);
        for (n = 0; n < 4000 && busy !== 1'b0; n++) @(negedge ref_clk);
        if (n == 4000) give_up();
        check({15'h0000, timeout}, 16'h0000);
    endtask
    ////////////////////////////////////////
    // scenarios
    task automatic t_reset();
        check({11'h000, pins.cs_n, pins.oe_n, pins.we_n, pins.oe_hv, dq_oe_n}, 16'h001d);
    endtask
    task automatic t_page();
        send(PEWP_CMD_WRITE, 15'h0140, 8'ha5, 1'b0);
        send(PEWP_CMD_WRITE, 15'h0141, 8'h5a, 1'b0);
        send(PEWP_CMD_WRITE, 15'h017f, 8'h80, 1'b1);
        wait_idle();
        rd(15'h0140, 8'ha5);
        rd(15'h0141, 8'h5a);
        rd(15'h017f, 8'h80);
    endtask
    task automatic t_bounds();
        fast_part = 1'b1;
        send(PEWP_CMD_WRITE, 15'h7fff, 8'h3c, 1'b1);
        wait_idle();
        send(PEWP_CMD_WRITE, 15'h0000, 8'hc3, 1'b1);
        wait_idle();
        fast_part = 1'b0;
        rd(15'h7fff, 8'h3c);
        rd(15'h0000, 8'hc3);
        rd(15'h1234, 8'hff);
    endtask
    task automatic t_queue();
        send(PEWP_CMD_WRITE, 15'h0200, 8'h7e, 1'b1);
        rd(15'h0200, 8'h7e);
        check({15'h0000, busy}, 16'h0000);
    endtask
    ////////////////////////////////////////
    // main sequence
    initial begin
        ref_clk = 1'b0;
        nrst = 1'b0;
        req = '0;
        req_valid = 1'b0;
        fast_part = 1'b0;
        repeat (3) @(negedge ref_clk);
        nrst = 1'b1;
        t_reset();
        t_page();
        t_bounds();
        t_queue();
        report_and_stop();
    end
endmodule // tb_top
bind pewp_host pewp_host_sva u_sva (.ref_clk(ref_clk), .nrst(nrst), .req(req), .req_valid(req_valid),
    .fast_part(fast_part), .req_ready(req_ready), .rd_valid(rd_valid), .rd_data(rd_data), .busy(busy),
    .timeout(timeout), .pins(pins), .dq_out(dq_out), .dq_oe_n(dq_oe_n), .dq_in(dq_in));
